// *** verilog/pei_pkg.sv ***
// Constants for the pin edge interrupt and pad input block
// Summary of operation
// - Reading the pad level register returns the present level of the seven pads in bits 6:0.
// - Bit 7 of the pad level register always reads as zero.
// - After reset the pad level register shows zero on top and the sampled pad levels below.
// - A pad's weak pull-up is on when its drive latch bit is 1 and off when it is 0.
// - A line's flag sets on a falling pin edge if its sense bit is 1, on a rising edge if 0.
// - Any flag at 1, even one written to 1, requests an interrupt when its enable is 1.
// - A set flag stays set until written to zero or reset, whatever further edges do.
// - The request persists while an enabled flag is set, so firmware must clear it.
// - Enable bits at 1 let a line's flag interrupt, at 0 they block it while the flag still records; the event summary still interrupts when its mask bit is 1.
// - The low flag and low enable registers hold lines 7:0 in bits 7:0.
// - The high flag register holds lines 11:8 in bits 3:0.
// - Bits 7:4 of the high flag register always read as zero.
// - Every reset clears the low flag, low enable and high flag registers.
// - The high enable register holds the enables of lines 11:8 in bits 3:0.
package pei_pkg;

    // Geometry
    localparam int PEI_NUM_LINES = 12;
    localparam int PEI_LO_LINES = 8;
    localparam int PEI_HI_LINES = 4;
    localparam int PEI_PAD_BITS = 7;
    localparam int PEI_EVT_BITS = 2;

    // Register indices; byte address is four times the index
    localparam logic [5:0] PEI_IDX_DRIVE = 6'h01;
    localparam logic [5:0] PEI_IDX_PAD1 = 6'h03;
    localparam logic [5:0] PEI_IDX_FLAGS_LO = 6'h04;
    localparam logic [5:0] PEI_IDX_EN_LO = 6'h05;
    localparam logic [5:0] PEI_IDX_FLAGS_HI = 6'h06;
    localparam logic [5:0] PEI_IDX_EN_HI = 6'h07;
    localparam logic [5:0] PEI_IDX_SENSE_LO = 6'h0a;
    localparam logic [5:0] PEI_IDX_SENSE_HI = 6'h0b;
    localparam logic [5:0] PEI_IDX_EVT_STAT = 6'h0c;
    localparam logic [5:0] PEI_IDX_EVT_MASK = 6'h0d;

    // Event status bit positions
    localparam int PEI_EVT_LO_POS = 0;
    localparam int PEI_EVT_HI_POS = 1;

    // Reset values
    localparam logic [6:0] PEI_DRIVE_RST = 7'h7f;
    localparam logic [7:0] PEI_FLAGS_LO_RST = 8'h00;
    localparam logic [7:0] PEI_EN_LO_RST = 8'h00;
    localparam logic [3:0] PEI_FLAGS_HI_RST = 4'h0;
    localparam logic [3:0] PEI_EN_HI_RST = 4'h0;
    localparam logic [7:0] PEI_SENSE_LO_RST = 8'h00;
    localparam logic [3:0] PEI_SENSE_HI_RST = 4'h0;
    localparam logic [1:0] PEI_EVT_RST = 2'h0;

    // Edges ignored until the synchroniser holds real pin samples
    localparam logic [1:0] PEI_PRIME_CYCLES = 2'h3;

endpackage

// *** verilog/pei_edge_if.sv ***
// Synchronised level and edge pulses passed from the edge detector
`timescale 1ns/1ps
interface pei_edge_if #(parameter int WIDTH = 12);
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// *** verilog/pei_edge_detect.sv ***
// Two-stage pin synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module pei_edge_detect
    import pei_pkg::*;
#(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous pins
    input wire logic [WIDTH-1:0] pin_in,
    // Synchronised results
    pei_edge_if.src edge_o
);

    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;
    logic [WIDTH-1:0] prev_reg;
    logic [1:0] prime_reg;
    logic armed;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                    prev_reg[i] <= 1'b0;
                end else begin
                    sync1_reg[i] <= pin_in[i];
                    sync2_reg[i] <= sync1_reg[i];
                    prev_reg[i] <= sync2_reg[i];
                end
            end
        end
    endgenerate

    // Suppress spurious edges while the pipeline fills after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prime_reg <= 2'h0;
        end else if (prime_reg != PEI_PRIME_CYCLES) begin
            prime_reg <= prime_reg + 2'h1;
        end
    end

    assign armed = (prime_reg == PEI_PRIME_CYCLES);
    assign edge_o.level = sync2_reg;
    assign edge_o.rise = armed ? (sync2_reg & ~prev_reg) : '0;
    assign edge_o.fall = armed ? (~sync2_reg & prev_reg) : '0;

    sync_rise_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((edge_o.rise & $past(pin_in, 2) & ~$past(pin_in, 3)) == edge_o.rise))
        else $error("rise pulse without a two-stage synchronised pin rise");

    sync_fall_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((edge_o.fall & ~$past(pin_in, 2) & $past(pin_in, 3)) == edge_o.fall))
        else $error("fall pulse without a two-stage synchronised pin fall");

endmodule

// *** verilog/pei_pin_edge_irq.sv ***
// Twelve-line edge interrupt controller and pad group 1 input register
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pei_pin_edge_irq
    import pei_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Avalon-MM slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // External interrupt pins
    input wire logic [PEI_NUM_LINES-1:0] IRQ_PIN,
    // Pad group 1
    input wire logic [PEI_PAD_BITS-1:0] PAD1_PIN,
    output logic [PEI_PAD_BITS-1:0] PAD1_PULLUP_EN,
    // Interrupt request to the core
    output logic IRQ
);

    pei_edge_if #(.WIDTH(PEI_NUM_LINES)) line_if ();
    pei_edge_if #(.WIDTH(PEI_PAD_BITS)) pad_if ();

    logic [5:0] idx;
    logic wr_lane;
    logic rd_first;
    logic rd_done;
    logic rd_ack_reg;
    logic [31:0] readdata_reg;
    logic [7:0] rd_mux;

    logic [PEI_PAD_BITS-1:0] drive_reg;
    logic [7:0] flags_lo_reg;
    logic [7:0] flags_lo_next;
    logic [7:0] en_lo_reg;
    logic [3:0] flags_hi_reg;
    logic [3:0] flags_hi_next;
    logic [3:0] en_hi_reg;
    logic [7:0] sense_lo_reg;
    logic [3:0] sense_hi_reg;
    logic [PEI_EVT_BITS-1:0] evt_reg;
    logic [PEI_EVT_BITS-1:0] evt_next;
    logic [PEI_EVT_BITS-1:0] evt_mask_reg;
    logic [PEI_EVT_BITS-1:0] evt_set;
    logic [PEI_EVT_BITS-1:0] evt_clr;

    logic [PEI_NUM_LINES-1:0] sense_all;
    logic [PEI_NUM_LINES-1:0] line_edge;
    logic [PEI_NUM_LINES-1:0] flags_all;
    logic [PEI_NUM_LINES-1:0] en_all;

    // Synchronisers for interrupt lines and pads
    pei_edge_detect #(.WIDTH(PEI_NUM_LINES)) u_line_det (
        .clk(CLK),
        .rst_n(RST_N),
        .pin_in(IRQ_PIN),
        .edge_o(line_if.src)
    );

    pei_edge_detect #(.WIDTH(PEI_PAD_BITS)) u_pad_det (
        .clk(CLK),
        .rst_n(RST_N),
        .pin_in(PAD1_PIN),
        .edge_o(pad_if.src)
    );

    // Edge selection per line
    assign sense_all = {sense_hi_reg, sense_lo_reg};
    assign line_edge = (sense_all & line_if.fall) | (~sense_all & line_if.rise);

    assign flags_all = {flags_hi_reg, flags_lo_reg};
    assign en_all = {en_hi_reg, en_lo_reg};

    // Bus decode
    assign idx = AVS_ADDRESS[7:2];
    assign wr_lane = AVS_WRITE & AVS_BYTEENABLE[0];
    assign rd_first = AVS_READ & ~rd_ack_reg;
    assign rd_done = AVS_READ & rd_ack_reg;
    assign AVS_WAITREQUEST = rd_first;
    assign AVS_READDATA = readdata_reg;

    always_comb begin
        case (idx)
            PEI_IDX_DRIVE: rd_mux = {1'b0, drive_reg};
            PEI_IDX_PAD1: rd_mux = {1'b0, pad_if.level};
            PEI_IDX_FLAGS_LO: rd_mux = flags_lo_reg;
            PEI_IDX_EN_LO: rd_mux = en_lo_reg;
            PEI_IDX_FLAGS_HI: rd_mux = {4'h0, flags_hi_reg};
            PEI_IDX_EN_HI: rd_mux = {4'h0, en_hi_reg};
            PEI_IDX_SENSE_LO: rd_mux = sense_lo_reg;
            PEI_IDX_SENSE_HI: rd_mux = {4'h0, sense_hi_reg};
            PEI_IDX_EVT_STAT: rd_mux = {6'h00, evt_reg};
            PEI_IDX_EVT_MASK: rd_mux = {6'h00, evt_mask_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read takes two edges: capture, then release
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_ack_reg <= 1'b0;
        end else begin
            rd_ack_reg <= rd_first;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            readdata_reg <= 32'h0000_0000;
        end else if (rd_first) begin
            readdata_reg <= {24'h00_0000, rd_mux};
        end
    end

    // Pull-up control latch
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            drive_reg <= PEI_DRIVE_RST;
        end else if (wr_lane && idx == PEI_IDX_DRIVE) begin
            drive_reg <= AVS_WRITEDATA[PEI_PAD_BITS-1:0];
        end
    end

    assign PAD1_PULLUP_EN = drive_reg;

    // Edge flags: write loads, a new edge always wins
    always_comb begin
        flags_lo_next = flags_lo_reg;
        flags_hi_next = flags_hi_reg;
        if (wr_lane && idx == PEI_IDX_FLAGS_LO) begin
            flags_lo_next = AVS_WRITEDATA[7:0];
        end
        if (wr_lane && idx == PEI_IDX_FLAGS_HI) begin
            flags_hi_next = AVS_WRITEDATA[3:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags_lo_reg <= PEI_FLAGS_LO_RST;
            flags_hi_reg <= PEI_FLAGS_HI_RST;
        end else begin
            flags_lo_reg <= flags_lo_next | line_edge[PEI_LO_LINES-1:0];
            flags_hi_reg <= flags_hi_next | line_edge[PEI_NUM_LINES-1:PEI_LO_LINES];
        end
    end

    // Enables
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            en_lo_reg <= PEI_EN_LO_RST;
            en_hi_reg <= PEI_EN_HI_RST;
        end else begin
            if (wr_lane && idx == PEI_IDX_EN_LO) begin
                en_lo_reg <= AVS_WRITEDATA[7:0];
            end
            if (wr_lane && idx == PEI_IDX_EN_HI) begin
                en_hi_reg <= AVS_WRITEDATA[3:0];
            end
        end
    end

    // Edge sense selection
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sense_lo_reg <= PEI_SENSE_LO_RST;
            sense_hi_reg <= PEI_SENSE_HI_RST;
        end else begin
            if (wr_lane && idx == PEI_IDX_SENSE_LO) begin
                sense_lo_reg <= AVS_WRITEDATA[7:0];
            end
            if (wr_lane && idx == PEI_IDX_SENSE_HI) begin
                sense_hi_reg <= AVS_WRITEDATA[3:0];
            end
        end
    end

    // Sticky event summary, cleared by read; only captured bits clear
    assign evt_set[PEI_EVT_LO_POS] = |line_edge[PEI_LO_LINES-1:0];
    assign evt_set[PEI_EVT_HI_POS] = |line_edge[PEI_NUM_LINES-1:PEI_LO_LINES];
    assign evt_clr = (rd_done && idx == PEI_IDX_EVT_STAT) ?
        readdata_reg[PEI_EVT_BITS-1:0] : '0;
    assign evt_next = (evt_reg & ~evt_clr) | evt_set;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            evt_reg <= PEI_EVT_RST;
        end else begin
            evt_reg <= evt_next;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            evt_mask_reg <= PEI_EVT_RST;
        end else if (wr_lane && idx == PEI_IDX_EVT_MASK) begin
            evt_mask_reg <= AVS_WRITEDATA[PEI_EVT_BITS-1:0];
        end
    end

    // Level request while any enabled flag stays set
    assign IRQ = (|(flags_all & en_all)) | (|(evt_reg & evt_mask_reg));

    pad_read_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (AVS_READ && !AVS_WAITREQUEST && idx == PEI_IDX_PAD1) |->
            (AVS_READDATA[6:0] == $past(pad_if.level)))
        else $error("pad level read does not match sampled pads");

    pad_top_zero_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (AVS_READ && !AVS_WAITREQUEST && idx == PEI_IDX_PAD1) |-> (AVS_READDATA[31:7] == '0))
        else $error("pad level reserved bit reads nonzero");

    pullup_follow_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (wr_lane && idx == PEI_IDX_DRIVE) |=> (PAD1_PULLUP_EN == $past(AVS_WRITEDATA[6:0])))
        else $error("pull-up enables do not follow drive latch write");

    edge_sets_flag_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (|line_edge) |=> ((flags_all & $past(line_edge)) == $past(line_edge)))
        else $error("selected edge did not set its flag");

    flag_irq_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (|(flags_all & en_all)) |-> IRQ)
        else $error("enabled flag without interrupt request");

    flag_sticky_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !(wr_lane && (idx == PEI_IDX_FLAGS_LO || idx == PEI_IDX_FLAGS_HI)) |=>
            ((flags_all & $past(flags_all)) == $past(flags_all)))
        else $error("flag cleared without a firmware write");

    irq_persist_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        ((|(flags_all & en_all)) && !wr_lane) |=> IRQ [*1])
        else $error("interrupt dropped while enabled flag still set");

    masked_quiet_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (en_all == '0 && evt_mask_reg == '0) |-> !IRQ)
        else $error("interrupt raised with every enable cleared");

    low_flags_read_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (AVS_READ && !AVS_WAITREQUEST && idx == PEI_IDX_FLAGS_LO) |->
            (AVS_READDATA[7:0] == $past(flags_lo_reg)))
        else $error("low flag read does not show lines 7 to 0");

    high_flags_read_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (AVS_READ && !AVS_WAITREQUEST && idx == PEI_IDX_FLAGS_HI) |->
            (AVS_READDATA[3:0] == $past(flags_all[11:8]) && AVS_READDATA[7:4] == 4'h0))
        else $error("high flag read wrong or reserved bits nonzero");

    read_answer_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (AVS_READ && AVS_WAITREQUEST) |=> (AVS_READ |-> !AVS_WAITREQUEST))
        else $error("read not answered on the second edge");

    pad_sync_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (RST_N && $past(RST_N) && $past(RST_N, 2)) |-> (pad_if.level == $past(PAD1_PIN, 2)))
        else $error("pad level does not follow the pins");

    reset_clear_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !$past(RST_N) |-> (flags_lo_reg == PEI_FLAGS_LO_RST && en_lo_reg == PEI_EN_LO_RST &&
            flags_hi_reg == PEI_FLAGS_HI_RST))
        else $error("flag or enable register not cleared by reset");

    rise_sense_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        ((line_edge & ~sense_all & ~(line_if.level & ~$past(line_if.level))) == '0))
        else $error("rising-sense line flagged without a rising level");

    fall_sense_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        ((line_edge & sense_all & ~(~line_if.level & $past(line_if.level))) == '0))
        else $error("falling-sense line flagged without a falling level");

    flag_rise_only_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !(wr_lane && (idx == PEI_IDX_FLAGS_LO || idx == PEI_IDX_FLAGS_HI)) |=>
            ((flags_all & ~$past(flags_all)) == ($past(line_edge) & ~$past(flags_all))))
        else $error("flag set without a selected edge");

    flag_load_lo_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (wr_lane && idx == PEI_IDX_FLAGS_LO) |=>
            (flags_lo_reg == ($past(AVS_WRITEDATA[7:0]) | $past(line_edge[7:0]))))
        else $error("low flag write not loaded with edges merged");

    flag_load_hi_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (wr_lane && idx == PEI_IDX_FLAGS_HI) |=>
            (flags_hi_reg == ($past(AVS_WRITEDATA[3:0]) | $past(line_edge[11:8]))))
        else $error("high flag write not loaded with edges merged");

    en_lo_write_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (wr_lane && idx == PEI_IDX_EN_LO) |=> (en_lo_reg == $past(AVS_WRITEDATA[7:0])))
        else $error("low enable write not loaded");

    en_hi_write_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (wr_lane && idx == PEI_IDX_EN_HI) |=> (en_hi_reg == $past(AVS_WRITEDATA[3:0])))
        else $error("high enable write not loaded");

    en_hold_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !(wr_lane && (idx == PEI_IDX_EN_LO || idx == PEI_IDX_EN_HI)) |=> $stable(en_all))
        else $error("enable changed without a write");

    en_lo_read_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (AVS_READ && !AVS_WAITREQUEST && idx == PEI_IDX_EN_LO) |->
            (AVS_READDATA[7:0] == $past(en_lo_reg)))
        else $error("low enable read does not show lines 7 to 0");

    en_hi_read_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (AVS_READ && !AVS_WAITREQUEST && idx == PEI_IDX_EN_HI) |->
            (AVS_READDATA[3:0] == $past(en_hi_reg) && AVS_READDATA[7:4] == 4'h0))
        else $error("high enable read wrong or reserved bits nonzero");

    evt_read_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (AVS_READ && !AVS_WAITREQUEST && idx == PEI_IDX_EVT_STAT) |->
            (AVS_READDATA[1:0] == $past(evt_reg) && AVS_READDATA[7:2] == 6'h00))
        else $error("event status read does not match status bits");

    evt_sticky_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !(rd_done && idx == PEI_IDX_EVT_STAT) |=>
            ((evt_reg & $past(evt_reg)) == $past(evt_reg)))
        else $error("event status cleared without a status read");

    evt_lo_set_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (|line_edge[PEI_LO_LINES-1:0]) |=> evt_reg[PEI_EVT_LO_POS])
        else $error("low line edge did not set its event bit");

    evt_hi_set_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (|line_edge[PEI_NUM_LINES-1:PEI_LO_LINES]) |=> evt_reg[PEI_EVT_HI_POS])
        else $error("high line edge did not set its event bit");

    pullup_hold_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !(wr_lane && idx == PEI_IDX_DRIVE) |=> $stable(PAD1_PULLUP_EN))
        else $error("pull-up enables changed without a drive latch write");

    be_ignored_a: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (AVS_WRITE && !AVS_BYTEENABLE[0]) |=>
            ($stable(en_all) && $stable(sense_all) && $stable(PAD1_PULLUP_EN)))
        else $error("write without its byte lane changed a register");

endmodule

// *** sim/pei_pin_model.sv ***
// External pin and pad model for the edge interrupt block
`timescale 1ns/1ps
module pei_pin_model
    import pei_pkg::*;
(
    // Clock
    input wire logic clk,
    // Pad control from the bench and the block
    input wire logic [PEI_PAD_BITS-1:0] pullup_en,
    input wire logic [PEI_PAD_BITS-1:0] pad_drive,
    input wire logic [PEI_PAD_BITS-1:0] pad_oe,
    // Interrupt pin levels from the bench
    input wire logic [PEI_NUM_LINES-1:0] irq_level,
    // Resolved wires
    output logic [PEI_PAD_BITS-1:0] pad_level,
    output logic [PEI_NUM_LINES-1:0] irq_pin
);
    logic [PEI_PAD_BITS-1:0] float_reg;

    // Undriven pad without pull-up wanders every cycle
    always_ff @(posedge clk) begin
        float_reg <= ~pad_level;
    end

    // Driven pad wins, else weak pull-up, else floating
    assign pad_level = (pad_oe & pad_drive) | (~pad_oe & pullup_en) |
        (~pad_oe & ~pullup_en & float_reg);
    assign irq_pin = irq_level;
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the edge interrupt and pad input block
`timescale 1ns/1ps
module tb_top;
    import pei_pkg::*;

    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [11:0] irq_level, irq_pin;
    logic [6:0] pad_drive, pad_oe, pad_level, pullup_en;
    int n_mismatch = 0;
    int comparisons = 0;
    localparam logic [5:0] RST_IDX [9] = '{PEI_IDX_FLAGS_LO, PEI_IDX_EN_LO, PEI_IDX_FLAGS_HI,
        PEI_IDX_EN_HI, PEI_IDX_SENSE_LO, PEI_IDX_SENSE_HI, PEI_IDX_EVT_MASK, PEI_IDX_DRIVE, 6'h3f};
    localparam logic [7:0] RST_VAL [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h7f, 8'h00};

    pei_pin_edge_irq u_pei_pin_edge_irq (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .IRQ_PIN(irq_pin), .PAD1_PIN(pad_level),
        .PAD1_PULLUP_EN(pullup_en), .IRQ(irq));
    pei_pin_model u_pei_pin_model (.clk(clk), .pullup_en(pullup_en), .pad_drive(pad_drive),
        .pad_oe(pad_oe), .irq_level(irq_level), .pad_level(pad_level), .irq_pin(irq_pin));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // One Avalon cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
        input logic [3:0] be, output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40) begin
            n_mismatch++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, 4'h1, q);
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, 4'h1, q);
        check(q, {24'h0, exp});
    endtask

    task automatic chk_irq(input logic e);
        @(negedge clk);
        check({31'h0, irq}, {31'h0, e});
        @(posedge clk);
    endtask

    task automatic pair_wr(input logic [5:0] lo, input logic [5:0] hi, input logic [11:0] v);
        wr(lo, v[7:0]);
        wr(hi, {4'h0, v[11:8]});
    endtask

    task automatic rdflags(input logic [11:0] v);
        rdc(PEI_IDX_FLAGS_LO, v[7:0]);
        rdc(PEI_IDX_FLAGS_HI, {4'h0, v[11:8]});
    endtask

    // Move one pin and let it cross the synchroniser
    task automatic setp(input logic [11:0] m, input logic v);
        @(posedge clk);
        irq_level <= (irq_level & ~m) | (v ? m : 12'h0);
        repeat (6) @(posedge clk);
    endtask

    task automatic reset_table();
        for (int k = 0; k < 9; k++) rdc(RST_IDX[k], RST_VAL[k]);
        check({25'h0, pullup_en}, 32'h7f);
        rdc(PEI_IDX_PAD1, {1'b0, pad_drive});
    endtask

    initial begin
        int unused;
        logic [31:0] q;
        logic [11:0] sn, m;
        logic [6:0] pv, lv;
        logic act;
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        irq_level = 12'h000;
        pad_drive = 7'h00;
        pad_oe = 7'h7f;
        unused = $urandom(77496);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        reset_table();
        // Pad sampling, read-only register and pull-ups
        repeat (4) begin
            pv = $urandom;
            @(posedge clk);
            pad_drive <= pv;
            repeat (3) @(posedge clk);
            rdc(PEI_IDX_PAD1, {1'b0, pv});
        end
        wr(PEI_IDX_PAD1, 8'hff);
        rdc(PEI_IDX_PAD1, {1'b0, pv});
        lv = $urandom;
        wr(PEI_IDX_DRIVE, {1'b0, lv});
        pad_oe <= 7'h00;
        repeat (3) @(posedge clk);
        check({25'h0, pullup_en}, {25'h0, lv});
        bus(1'b0, PEI_IDX_PAD1, 8'h00, 4'h1, q);
        check(q & {25'h0, lv}, {25'h0, lv});
        pad_oe <= 7'h7f;
        // Every line, random sense selection
        for (int i = 0; i < 12; i++) begin
            m = 12'h1 << i;
            sn = $urandom;
            act = ~sn[i];
            pair_wr(PEI_IDX_SENSE_LO, PEI_IDX_SENSE_HI, sn);
            setp(m, act);
            pair_wr(PEI_IDX_FLAGS_LO, PEI_IDX_FLAGS_HI, 12'h0);
            setp(m, ~act);
            rdflags(12'h0);
            bus(1'b0, PEI_IDX_EVT_STAT, 8'h00, 4'h1, q);
            setp(m, act);
            rdflags(m);
            setp(m, ~act);
            setp(m, act);
            rdflags(m);
            wr(PEI_IDX_EVT_MASK, 8'h03);
            chk_irq(1'b1);
            rdc(PEI_IDX_EVT_STAT, (i < 8) ? 8'h01 : 8'h02);
            chk_irq(1'b0);
            rdc(PEI_IDX_EVT_STAT, 8'h00);
            wr(PEI_IDX_EVT_MASK, 8'h00);
            pair_wr(PEI_IDX_EN_LO, PEI_IDX_EN_HI, m);
            chk_irq(1'b1);
            pair_wr(PEI_IDX_EN_LO, PEI_IDX_EN_HI, 12'h0);
            chk_irq(1'b0);
            rdflags(m);
            pair_wr(PEI_IDX_EN_LO, PEI_IDX_EN_HI, m);
            chk_irq(1'b1);
            pair_wr(PEI_IDX_FLAGS_LO, PEI_IDX_FLAGS_HI, 12'h0);
            chk_irq(1'b0);
            pair_wr(PEI_IDX_EN_LO, PEI_IDX_EN_HI, 12'h0);
        end
        // Firmware-set flags, reserved bits, ignored byte lane
        wr(PEI_IDX_EN_HI, 8'hff);
        rdc(PEI_IDX_EN_HI, 8'h0f);
        wr(PEI_IDX_FLAGS_HI, 8'hff);
        rdc(PEI_IDX_FLAGS_HI, 8'h0f);
        chk_irq(1'b1);
        wr(PEI_IDX_FLAGS_HI, 8'h00);
        chk_irq(1'b0);
        bus(1'b1, PEI_IDX_EN_LO, 8'hff, 4'h0, q);
        rdc(PEI_IDX_EN_LO, 8'h00);
        // Reset in mid-run with live flags
        wr(PEI_IDX_EN_LO, 8'ha5);
        wr(PEI_IDX_FLAGS_LO, 8'hff);
        chk_irq(1'b1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_irq(1'b0);
        reset_table();
        complete_run();
    end
endmodule
